// ==== tsp_serial_port.sv ====
// Three-wire serial slave port and register bank of the temperature sensor
`timescale 1ns/1ps
`default_nettype none
module tsp_serial_port (
	// Clock, reset, enable
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	// Serial link pins
	input wire logic cs_n_in,
	input wire logic sclk_in,
	input wire logic serial_io_in,
	output logic serial_io_out,
	output logic serial_io_oe_out,
	// Converter
	input wire logic conv_done_in,
	input wire logic [12:0] conv_data_in,
	output logic conv_start_out,
	output logic conv_abort_out,
	output logic shutdown_out,
	// Open-drain fault pins, driven low while enabled
	output logic warning_oe_out,
	output logic overheat_output_oe_out
);
	// Upper nine bits of a register as a signed 10-bit value
	function automatic logic signed [9:0] lim10(input logic [15:0] v);
		lim10 = signed'({v[15], v[15:tsp_pkg::LIM_LSB]});
	endfunction
	// One when the byte is one of the eleven commands
	function automatic logic cmd_known(input logic [7:0] c);
		case (c)
			tsp_pkg::CMD_RD_TEMP, tsp_pkg::CMD_RD_CFG, tsp_pkg::CMD_RD_HYST,
			tsp_pkg::CMD_RD_CRIT, tsp_pkg::CMD_RD_LOW, tsp_pkg::CMD_RD_HIGH,
			tsp_pkg::CMD_WR_CFG, tsp_pkg::CMD_WR_HYST, tsp_pkg::CMD_WR_CRIT,
			tsp_pkg::CMD_WR_LOW, tsp_pkg::CMD_WR_HIGH: cmd_known = 1'b1;
			default: cmd_known = 1'b0;
		endcase
	endfunction

	// Pin synchronisers; first stage feeds only the second
	logic [1:0] cs_sync_r, sclk_sync_r, sio_sync_r;
	logic cs_prev_r, sclk_prev_r;

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cs_sync_r <= 2'h3;
			sclk_sync_r <= 2'h0;
			sio_sync_r <= 2'h0;
			cs_prev_r <= 1'b1;
			sclk_prev_r <= 1'b0;
		end else if (clk_en_in) begin
			cs_sync_r <= {cs_sync_r[0], cs_n_in};
			sclk_sync_r <= {sclk_sync_r[0], sclk_in};
			sio_sync_r <= {sio_sync_r[0], serial_io_in};
			cs_prev_r <= cs_sync_r[1];
			sclk_prev_r <= sclk_sync_r[1];
		end
	end

	logic cs_n_s, sio_s, cs_fall, cs_rise, sclk_rise, sclk_fall;
	assign cs_n_s = cs_sync_r[1];
	assign sio_s = sio_sync_r[1];
	assign cs_fall = cs_prev_r && !cs_n_s;
	assign cs_rise = !cs_prev_r && cs_n_s;
	// Clock edges count only inside a frame
	assign sclk_rise = !cs_n_s && !sclk_prev_r && sclk_sync_r[1];
	assign sclk_fall = !cs_n_s && sclk_prev_r && !sclk_sync_r[1];

	// Frame sequencer
	tsp_pkg::tsp_state_t state_r;
	logic [4:0] cnt_r;
	logic [7:0] cmd_r;
	logic [15:0] wdata_r;
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r <= tsp_pkg::ST_IDLE;
			cnt_r <= 5'h00;
		end else if (clk_en_in) begin
			case (state_r)
				tsp_pkg::ST_IDLE: begin
					if (cs_fall) begin
						state_r <= tsp_pkg::ST_CMD;
						cnt_r <= 5'h00;
					end
				end
				tsp_pkg::ST_CMD: begin
					if (cs_rise) begin
						state_r <= tsp_pkg::ST_IDLE;
					end else if (sclk_rise) begin
						cnt_r <= cnt_r + 5'h01;
						if (cnt_r + 5'h01 == tsp_pkg::CNT_CMD_DONE) begin
							state_r <= tsp_pkg::ST_DATA;
						end
					end
				end
				tsp_pkg::ST_DATA: begin
					if (cs_rise) begin
						state_r <= tsp_pkg::ST_IDLE;
					end else if (sclk_rise) begin
						cnt_r <= cnt_r + 5'h01;
						if (cnt_r == tsp_pkg::CNT_FRAME) begin
							state_r <= tsp_pkg::ST_BAD;
						end
					end
				end
				tsp_pkg::ST_BAD: begin
					if (cs_rise) begin
						state_r <= tsp_pkg::ST_IDLE;
					end
				end
				default: begin
					state_r <= tsp_pkg::ST_IDLE;
					cnt_r <= 5'h00;
				end
			endcase
		end
	end

	// Command and write data shift in, MSB first on rising clock
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cmd_r <= 8'h00;
			wdata_r <= 16'h0000;
		end else if (clk_en_in && sclk_rise) begin
			if (state_r == tsp_pkg::ST_CMD) begin
				cmd_r <= {cmd_r[6:0], sio_s};
			end else if (state_r == tsp_pkg::ST_DATA) begin
				wdata_r <= {wdata_r[14:0], sio_s};
			end
		end
	end

	logic cmd_valid, cmd_is_read, cmd_ready;
	// Start bit and direction bit qualify the byte
	assign cmd_valid = cmd_r[tsp_pkg::CMD_START_BIT] && cmd_known(cmd_r);
	assign cmd_is_read = cmd_r[tsp_pkg::CMD_READ_BIT];
	assign cmd_ready = state_r == tsp_pkg::ST_DATA && cnt_r == tsp_pkg::CNT_CMD_DONE;

	// Registers
	logic [15:0] temp_r, hyst_r, crit_r, low_r, high_r, cfg_word;
	tsp_pkg::tsp_cfg_t cfg_r;

	// Reserved bits read as zero
	assign cfg_word = {3'h0, cfg_r.fault_queue, cfg_r.warn_pol, cfg_r.ot_pol,
		cfg_r.int_mode, cfg_r.shutdown, 8'h00};
	logic commit;
	// Full 24-clock frame, valid write command
	assign commit = cs_rise && state_r == tsp_pkg::ST_DATA && cnt_r == tsp_pkg::CNT_FRAME &&
		cmd_valid && !cmd_is_read;
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cfg_r <= tsp_pkg::tsp_cfg_t'(5'h00);
			hyst_r <= tsp_pkg::RST_HYST;
			crit_r <= tsp_pkg::RST_CRIT;
			low_r <= tsp_pkg::RST_LOW;
			high_r <= tsp_pkg::RST_HIGH;
		end else if (clk_en_in && commit) begin
			case (cmd_r)
				tsp_pkg::CMD_WR_CFG: begin
					cfg_r.fault_queue <= wdata_r[tsp_pkg::CFG_QUEUE_BIT];
					cfg_r.warn_pol <= wdata_r[tsp_pkg::CFG_WARN_POL_BIT];
					cfg_r.ot_pol <= wdata_r[tsp_pkg::CFG_OT_POL_BIT];
					cfg_r.int_mode <= wdata_r[tsp_pkg::CFG_INT_MODE_BIT];
					cfg_r.shutdown <= wdata_r[tsp_pkg::CFG_SHUTDOWN_BIT];
				end
				tsp_pkg::CMD_WR_HYST: hyst_r <= wdata_r & tsp_pkg::LIM_MASK;
				tsp_pkg::CMD_WR_CRIT: crit_r <= wdata_r & tsp_pkg::LIM_MASK;
				tsp_pkg::CMD_WR_LOW: low_r <= wdata_r & tsp_pkg::LIM_MASK;
				tsp_pkg::CMD_WR_HIGH: high_r <= wdata_r & tsp_pkg::LIM_MASK;
				default: begin
				end
			endcase
		end
	end

	// Read word picked when the command byte completes
	logic [15:0] rd_word;
	always_comb begin
		case (cmd_r)
			tsp_pkg::CMD_RD_TEMP: rd_word = temp_r;
			tsp_pkg::CMD_RD_CFG: rd_word = cfg_word;
			tsp_pkg::CMD_RD_HYST: rd_word = hyst_r;
			tsp_pkg::CMD_RD_CRIT: rd_word = crit_r;
			tsp_pkg::CMD_RD_LOW: rd_word = low_r;
			tsp_pkg::CMD_RD_HIGH: rd_word = high_r;
			default: rd_word = 16'h0000;
		endcase
	end

	// Output shifter; drives from the eighth falling edge until select rises
	logic [15:0] rshift_r;
	logic drive_r, rd_ok;
	assign rd_ok = cmd_ready && cmd_valid && cmd_is_read;
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rshift_r <= 16'h0000;
			drive_r <= 1'b0;
		end else if (clk_en_in) begin
			if (cs_n_s || state_r == tsp_pkg::ST_IDLE) begin
				drive_r <= 1'b0;
			end else if (sclk_fall) begin
				if (rd_ok && !drive_r) begin
					rshift_r <= rd_word;
					drive_r <= 1'b1;
				end else if (drive_r) begin
					rshift_r <= {rshift_r[14:0], 1'b0};
				end
			end
		end
	end

	// Unknown or write commands leave the line undriven
	assign serial_io_out = rshift_r[15];
	assign serial_io_oe_out = drive_r && !cs_n_s;
	// Converter control pulses
	logic temp_rd;
	assign temp_rd = rd_ok && sclk_fall && !drive_r && cmd_r == tsp_pkg::CMD_RD_TEMP;
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			conv_start_out <= 1'b0;
			conv_abort_out <= 1'b0;
		end else if (clk_en_in) begin
			conv_start_out <= cs_fall && !cfg_r.shutdown;
			conv_abort_out <= temp_rd;
		end
	end
	assign shutdown_out = cfg_r.shutdown;
	// Fault evaluation on each accepted result; shutdown freezes it
	logic sample, over_high, under_low, below_high_h, above_low_h, over_crit, below_crit_h;
	logic signed [9:0] t10, hy10;

	// An abort in flight discards the finishing result
	assign sample = conv_done_in && !cfg_r.shutdown && !temp_rd;
	assign t10 = signed'({conv_data_in[12], conv_data_in[12:4]});
	assign hy10 = lim10(hyst_r);
	assign over_high = t10 > lim10(high_r);
	assign under_low = t10 < lim10(low_r);
	assign below_high_h = t10 < lim10(high_r) - hy10;
	assign above_low_h = t10 > lim10(low_r) + hy10;
	assign over_crit = t10 > lim10(crit_r);
	assign below_crit_h = t10 < lim10(crit_r) - hy10;
	logic warn_r, ot_r, seek_return_r, from_low_r, warn_cond, warn_hit, ot_hit;

	// Interrupt mode looks for the return crossing after each out-of-limit event
	always_comb begin
		if (cfg_r.int_mode && seek_return_r) begin
			warn_cond = from_low_r ? above_low_h : below_high_h;
		end else begin
			warn_cond = over_high || under_low;
		end
	end

	tsp_fault_qual #(
		.DEPTH(tsp_pkg::QUEUE_DEPTH)
	) u_warn_qual (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.clk_en_in(clk_en_in),
		.sample_in(sample),
		.cond_in(warn_cond),
		.queue_en_in(cfg_r.fault_queue),
		.hit_out(warn_hit)
	);

	tsp_fault_qual #(
		.DEPTH(tsp_pkg::QUEUE_DEPTH)
	) u_ot_qual (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.clk_en_in(clk_en_in),
		.sample_in(sample),
		.cond_in(over_crit),
		.queue_en_in(cfg_r.fault_queue),
		.hit_out(ot_hit)
	);

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			warn_r <= 1'b0;
			seek_return_r <= 1'b0;
			from_low_r <= 1'b0;
		end else if (clk_en_in) begin
			if (cfg_r.int_mode) begin
				if (warn_hit) begin
					warn_r <= 1'b1;
					if (!seek_return_r) begin
						from_low_r <= under_low && !over_high;
					end
					seek_return_r <= !seek_return_r;
				end else if (temp_rd) begin
					warn_r <= 1'b0;
				end
			end else begin
				seek_return_r <= 1'b0;
				if (warn_hit) begin
					warn_r <= 1'b1;
				end else if (sample && below_high_h && above_low_h) begin
					warn_r <= 1'b0;
				end
			end
		end
	end

	// Overheat is always comparator style; reads do not clear it
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ot_r <= 1'b0;
		end else if (clk_en_in) begin
			if (ot_hit) begin
				ot_r <= 1'b1;
			end else if (sample && below_crit_h) begin
				ot_r <= 1'b0;
			end
		end
	end

	// Temperature register: result plus flags, bit 0 reads zero
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			temp_r <= tsp_pkg::RST_TEMP;
		end else if (clk_en_in && sample) begin
			temp_r[15:tsp_pkg::TEMP_DATA_LSB] <= conv_data_in;
			temp_r[tsp_pkg::TEMP_OVER_BIT] <= ot_hit || (ot_r && !below_crit_h);
			temp_r[tsp_pkg::TEMP_HIGH_BIT] <= over_high;
			temp_r[0] <= 1'b0;
		end
	end

	// Pin enables: an open drain pulls low when the level is to be low
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			warning_oe_out <= 1'b0;
			overheat_output_oe_out <= 1'b0;
		end else if (clk_en_in) begin
			warning_oe_out <= warn_r ^ cfg_r.warn_pol;
			overheat_output_oe_out <= ot_r ^ cfg_r.ot_pol;
		end
	end
endmodule
`default_nettype wire

// ==== tsp_pkg.sv ====
// Constants, command codes and types of the temperature sensor serial port
package tsp_pkg;
	// Frame shape
	localparam int unsigned CMD_BITS = 8;
	localparam int unsigned FRAME_CLOCKS = 24;
	localparam logic [4:0] CNT_CMD_DONE = 5'h08;
	localparam logic [4:0] CNT_FRAME = 5'h18;
	localparam logic [4:0] CNT_OVER = 5'h19;
	// Command byte fields
	localparam int unsigned CMD_START_BIT = 7;
	localparam int unsigned CMD_READ_BIT = 6;
	// Read commands
	localparam logic [7:0] CMD_RD_TEMP = 8'hC1;
	localparam logic [7:0] CMD_RD_CFG = 8'hC3;
	localparam logic [7:0] CMD_RD_HYST = 8'hC5;
	localparam logic [7:0] CMD_RD_CRIT = 8'hC7;
	localparam logic [7:0] CMD_RD_LOW = 8'hC9;
	localparam logic [7:0] CMD_RD_HIGH = 8'hCB;
	// Write commands
	localparam logic [7:0] CMD_WR_CFG = 8'h83;
	localparam logic [7:0] CMD_WR_HYST = 8'h85;
	localparam logic [7:0] CMD_WR_CRIT = 8'h87;
	localparam logic [7:0] CMD_WR_LOW = 8'h89;
	localparam logic [7:0] CMD_WR_HIGH = 8'h8B;
	// Configuration bit positions
	localparam int unsigned CFG_QUEUE_BIT = 12;
	localparam int unsigned CFG_WARN_POL_BIT = 11;
	localparam int unsigned CFG_OT_POL_BIT = 10;
	localparam int unsigned CFG_INT_MODE_BIT = 9;
	localparam int unsigned CFG_SHUTDOWN_BIT = 8;
	// Temperature register layout
	localparam int unsigned TEMP_DATA_LSB = 3;
	localparam int unsigned TEMP_OVER_BIT = 2;
	localparam int unsigned TEMP_HIGH_BIT = 1;
	// Limit registers keep only the upper nine bits
	localparam int unsigned LIM_LSB = 7;
	localparam logic [15:0] LIM_MASK = 16'hFF80;
	// Values after reset
	localparam logic [15:0] RST_TEMP = 16'h0000;
	localparam logic [15:0] RST_CFG = 16'h0000;
	localparam logic [15:0] RST_HYST = 16'h0100;
	localparam logic [15:0] RST_CRIT = 16'h2800;
	localparam logic [15:0] RST_LOW = 16'h0500;
	localparam logic [15:0] RST_HIGH = 16'h2000;
	// Fault queue depth
	localparam int unsigned QUEUE_DEPTH = 4;

	typedef struct packed {
		logic fault_queue;
		logic warn_pol;
		logic ot_pol;
		logic int_mode;
		logic shutdown;
	} tsp_cfg_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_CMD = 4'h2,
		ST_DATA = 4'h4,
		ST_BAD = 4'h8
	} tsp_state_t;
endpackage

// ==== tsp_fault_qual.sv ====
// Consecutive-conversion fault qualifier
`timescale 1ns/1ps
`default_nettype none
module tsp_fault_qual #(
	parameter int unsigned DEPTH = tsp_pkg::QUEUE_DEPTH
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	// Conversion results
	input wire logic sample_in,
	input wire logic cond_in,
	input wire logic queue_en_in,
	// Qualified fault
	output logic hit_out
);
	// Run counter is four bits, so deeper queues cannot be served
	if (DEPTH < 2 || DEPTH > 15) begin : g_depth_bad
		$error("tsp_fault_qual: DEPTH out of range");
	end

	logic [3:0] run_r;
	logic [3:0] need;

	assign need = queue_en_in ? 4'(DEPTH) : 4'h1;
	// Hit on the conversion that completes the run
	// Five-bit sum so a saturated run does not wrap to zero
	assign hit_out = sample_in && cond_in && (({1'b0, run_r} + 5'h01) >= {1'b0, need});

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			run_r <= 4'h0;
		end else if (clk_en_in && sample_in) begin
			if (!cond_in) begin
				run_r <= 4'h0;
			end else if (run_r != 4'hF) begin
				run_r <= run_r + 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== tsp_serial_port_chk.sv ====
// Port-level assertions of the temperature sensor serial port
`timescale 1ns/1ps
`default_nettype none
module tsp_serial_port_chk (
	// Clock, reset, enable
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	// Serial link pins
	input wire logic cs_n_in,
	input wire logic sclk_in,
	input wire logic serial_io_in,
	input wire logic serial_io_out,
	input wire logic serial_io_oe_out,
	// Converter
	input wire logic conv_done_in,
	input wire logic [12:0] conv_data_in,
	input wire logic conv_start_out,
	input wire logic conv_abort_out,
	input wire logic shutdown_out,
	// Fault pins
	input wire logic warning_oe_out,
	input wire logic overheat_output_oe_out
);
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	sequence s_sel_idle;
		cs_n_in [*4];
	endsequence
	sequence s_pulse_end;
		##1 !conv_abort_out;
	endsequence
	chk_idle_quiet: assert property (s_sel_idle |-> !serial_io_oe_out)
		else $error("data pin driven while deselected");
	chk_drive_fall: assert property ($rose(serial_io_oe_out) |-> !$past(sclk_in) && !cs_n_in)
		else $error("drive began off a clock fall");
	chk_shift_fall: assert property ($changed(serial_io_out) |-> !$past(sclk_in))
		else $error("output bit moved off a clock fall");
	chk_drive_hold: assert property ($fell(serial_io_oe_out) |-> cs_n_in)
		else $error("drive released before select rose");
	chk_commit_sel: assert property ($changed(shutdown_out) |-> cs_n_in)
		else $error("configuration changed inside a frame");
	chk_start_pulse: assert property (conv_start_out |=> !conv_start_out)
		else $error("start pulse longer than one cycle");
	chk_start_live: assert property (conv_start_out |-> !cs_n_in && !shutdown_out)
		else $error("start outside an access or in shutdown");
	chk_abort_read: assert property (conv_abort_out |-> serial_io_oe_out and s_pulse_end)
		else $error("abort outside a read");
endmodule
`default_nettype wire

// ==== tsp_master_model.sv ====
// Serial bus master model driving select, clock and the shared data line
`timescale 1ns/1ps
`default_nettype none
module tsp_master_model (
	// Clock
	input wire logic sys_clk_in,
	// Device side of the data pin
	input wire logic dev_io_in,
	input wire logic dev_oe_in,
	// Link pins
	output logic cs_n_out,
	output logic sclk_out,
	output logic io_out
);
	logic m_oe_r = 1'b0;
	logic m_bit_r = 1'b0;
	logic last_r = 1'b0;
	// Undriven line toggles so a stale value never looks valid
	assign io_out = m_oe_r ? m_bit_r : (dev_oe_in ? dev_io_in : ~last_r);
	always_ff @(posedge sys_clk_in) begin
		last_r <= io_out;
	end
	initial begin
		cs_n_out = 1'b1;
		sclk_out = 1'b0;
	end
	// Sel low keeps select high while clocking
	task automatic frame(input logic sel, input logic [7:0] cmd, input logic [15:0] wd,
		input int n, output logic [15:0] rd, output logic drove);
		logic [23:0] sh;
		sh = {cmd, wd};
		rd = 16'h0000;
		drove = 1'b0;
		@(posedge sys_clk_in);
		cs_n_out <= ~sel;
		repeat (4) @(posedge sys_clk_in);
		for (int i = 0; i < n; i++) begin
			m_oe_r <= (i < 8) || !cmd[6];
			m_bit_r <= sh[23 - (i % 24)];
			repeat (4) @(posedge sys_clk_in);
			sclk_out <= 1'b1;
			if (i >= 8) begin
				rd = {rd[14:0], io_out};
				drove = drove | dev_oe_in;
			end
			repeat (4) @(posedge sys_clk_in);
			sclk_out <= 1'b0;
		end
		repeat (4) @(posedge sys_clk_in);
		cs_n_out <= 1'b1;
		m_oe_r <= 1'b0;
		repeat (6) @(posedge sys_clk_in);
	endtask
endmodule
`default_nettype wire

// ==== tsp_serial_port_bench.sv ====
// Self-checking bench of the temperature sensor serial port
`timescale 1ns/1ps
`default_nettype none
module tsp_serial_port_bench;
	typedef struct packed {
		logic [7:0] wr_cmd;
		logic [15:0] wr_data;
		logic [7:0] rd_cmd;
		logic [15:0] exp;
	} tsp_row_t;
	localparam int NROWS = 12;
	// Write code 00h means read only
	localparam tsp_row_t ROWS [NROWS] = '{
		'{8'h00, 16'h0000, 8'hC3, 16'h0000}, '{8'h00, 16'h0000, 8'hC1, 16'h0000},
		'{8'h00, 16'h0000, 8'hC5, 16'h0100}, '{8'h00, 16'h0000, 8'hC7, 16'h2800},
		'{8'h00, 16'h0000, 8'hC9, 16'h0500}, '{8'h00, 16'h0000, 8'hCB, 16'h2000},
		'{8'h85, 16'h01FF, 8'hC5, 16'h0180}, '{8'h87, 16'h327F, 8'hC7, 16'h3200},
		'{8'h89, 16'h0A55, 8'hC9, 16'h0A00}, '{8'h8B, 16'h3C7F, 8'hCB, 16'h3C00},
		'{8'h83, 16'hFEFF, 8'hC3, 16'h1E00}, '{8'h83, 16'h0000, 8'hC3, 16'h0000}
	};
	localparam logic [12:0] HOT = 13'h06E0;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	int n_start = 0;
	int n_abort = 0;
	int s0;
	int a0;
	logic conv_done = 1'b0;
	logic [12:0] conv_data = 13'h0000;
	logic cs_n;
	logic sclk;
	logic io;
	logic dev_out;
	logic dev_oe;
	logic conv_start;
	logic conv_abort;
	logic shutdown;
	logic warn_oe;
	logic ot_oe;
	logic [15:0] rd;
	logic drove;
	int error_cnt = 0;
	int checks_done = 0;
	tsp_serial_port u_tsp_serial_port (
		.sys_clk_in(sys_clk), .rst_n_in(rst_n), .clk_en_in(clk_en),
		.cs_n_in(cs_n), .sclk_in(sclk), .serial_io_in(io),
		.serial_io_out(dev_out), .serial_io_oe_out(dev_oe),
		.conv_done_in(conv_done), .conv_data_in(conv_data), .conv_start_out(conv_start),
		.conv_abort_out(conv_abort), .shutdown_out(shutdown),
		.warning_oe_out(warn_oe), .overheat_output_oe_out(ot_oe)
	);
	tsp_master_model u_tsp_master_model (
		.sys_clk_in(sys_clk), .dev_io_in(dev_out), .dev_oe_in(dev_oe),
		.cs_n_out(cs_n), .sclk_out(sclk), .io_out(io)
	);
	always #25 sys_clk = ~sys_clk;
	// Converter pulses are tallied for the access tests
	always @(posedge sys_clk) begin
		if (conv_start === 1'b1) begin
			n_start <= n_start + 1;
		end
		if (conv_abort === 1'b1) begin
			n_abort <= n_abort + 1;
		end
	end
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, input int n);
		u_tsp_master_model.frame(1'b1, cmd, wd, n, rd, drove);
	endtask
	task automatic conv(input logic [12:0] d, input int n);
		repeat (n) begin
			@(posedge sys_clk);
			conv_done <= 1'b1;
			conv_data <= d;
			@(posedge sys_clk);
			conv_done <= 1'b0;
			repeat (5) @(posedge sys_clk);
		end
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge sys_clk);
		error_cnt++;
		final_report();
	end
	initial begin
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		for (int i = 0; i < NROWS; i++) begin
			if (ROWS[i].wr_cmd != 8'h00) begin
				xfer(ROWS[i].wr_cmd, ROWS[i].wr_data, 24);
			end
			xfer(ROWS[i].rd_cmd, 16'h0000, 24);
			chk_word(rd, ROWS[i].exp);
		end
		$display("test table done");
		conv(13'h0190, 1);
		foreach (ROWS[i]) begin
			if (i < 4) begin
				xfer(i == 0 ? 8'hC2 : (i == 1 ? 8'h41 : (i == 2 ? 8'h81 : 8'hCD)), 16'hFFFF, 24);
				chk_bit(drove, 1'b0);
			end
		end
		xfer(8'hC1, 16'h0000, 24);
		chk_word(rd, 16'h0C80);
		$display("test codes done");
		xfer(8'h83, 16'h0100, 23);
		xfer(8'h83, 16'h0100, 25);
		u_tsp_master_model.frame(1'b0, 8'h83, 16'h0100, 24, rd, drove);
		xfer(8'hC3, 16'h0000, 24);
		chk_word(rd, 16'h0000);
		$display("test framing done");
		xfer(8'h83, 16'h0100, 24);
		chk_bit(shutdown, 1'b1);
		conv(HOT, 1);
		xfer(8'hC1, 16'h0000, 24);
		chk_word(rd, 16'h0C80);
		xfer(8'hC3, 16'h0000, 24);
		chk_word(rd, 16'h0100);
		xfer(8'h83, 16'h0C00, 24);
		chk_bit(shutdown, 1'b0);
		chk_bit(warn_oe, 1'b1);
		chk_bit(ot_oe, 1'b1);
		$display("test shutdown done");
		xfer(8'h83, 16'h1000, 24);
		conv(HOT, 3);
		chk_bit(ot_oe, 1'b0);
		conv(HOT, 1);
		chk_bit(ot_oe, 1'b1);
		conv(13'h0190, 1);
		chk_bit(ot_oe, 1'b0);
		xfer(8'h83, 16'h0000, 24);
		conv(HOT, 1);
		chk_bit(ot_oe, 1'b1);
		$display("test queue done");
		xfer(8'hC1, 16'h0000, 24);
		chk_word(rd, 16'h3704);
		conv(13'h07D0, 1);
		chk_bit(warn_oe, 1'b1);
		xfer(8'hC1, 16'h0000, 24);
		chk_word(rd, 16'h3E86);
		chk_bit(warn_oe, 1'b1);
		xfer(8'h83, 16'h0200, 24);
		conv(13'h07D0, 1);
		s0 = n_start;
		a0 = n_abort;
		xfer(8'hC1, 16'h0000, 24);
		chk_word(rd, 16'h3E86);
		chk_word(16'(n_abort - a0), 16'h0001);
		chk_word(16'(n_start - s0), 16'h0001);
		chk_bit(warn_oe, 1'b0);
		conv(13'h07D0, 1);
		chk_bit(warn_oe, 1'b0);
		conv(13'h0190, 1);
		chk_bit(warn_oe, 1'b1);
		$display("test alert done");
		rst_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk_bit(ot_oe, 1'b0);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		xfer(8'hC7, 16'h0000, 24);
		chk_word(rd, 16'h2800);
		// Frozen clock enable must drop this result
		clk_en <= 1'b0;
		conv(HOT, 1);
		clk_en <= 1'b1;
		xfer(8'hC1, 16'h0000, 24);
		chk_word(rd, 16'h0000);
		$display("test reset done");
		final_report();
	end
endmodule
bind tsp_serial_port tsp_serial_port_chk u_tsp_serial_port_chk (
	.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
	.cs_n_in(cs_n_in), .sclk_in(sclk_in), .serial_io_in(serial_io_in),
	.serial_io_out(serial_io_out), .serial_io_oe_out(serial_io_oe_out),
	.conv_done_in(conv_done_in), .conv_data_in(conv_data_in),
	.conv_start_out(conv_start_out), .conv_abort_out(conv_abort_out),
	.shutdown_out(shutdown_out), .warning_oe_out(warning_oe_out),
	.overheat_output_oe_out(overheat_output_oe_out)
);
`default_nettype wire
